// ===== common/csior_cfg.svh
// Constants of the core system IO register group: addresses, bit
// positions, reset values and clock selection codes.
// Assumes inclusion by bare name from the package and the design files.
`ifndef CSIOR_CFG_SVH
`define CSIOR_CFG_SVH

// Register addresses in the IO space
`define CSIOR_ADDR_FLAGS   6'h00
`define CSIOR_ADDR_STACK   6'h02
`define CSIOR_ADDR_CLKMODE 6'h03
`define CSIOR_ADDR_INTEN   6'h04
`define CSIOR_ADDR_INTREQ  6'h05

// Status flag bit positions and implemented bits
`define CSIOR_FLAG_OV      3
`define CSIOR_FLAG_HC      2
`define CSIOR_FLAG_C       1
`define CSIOR_FLAG_Z       0
`define CSIOR_FLAG_MASK    8'h0F

// Clock mode field positions
`define CSIOR_CM_SEL_HI    7
`define CSIOR_CM_SEL_LO    5
`define CSIOR_CM_HRC_EN    4
`define CSIOR_CM_TYPE      3
`define CSIOR_CM_LRC_EN    2
`define CSIOR_CM_WDT_EN    1
`define CSIOR_CM_RST_PIN   0

// Interrupt bits implemented (bit 5 reserved)
`define CSIOR_IRQ_MASK     8'hDF

// Reset values
`define CSIOR_FLAGS_RST    4'h0
`define CSIOR_STACK_RST    8'h00
`define CSIOR_CLKMODE_RST  8'hF6
`define CSIOR_INTEN_RST    8'h00
`define CSIOR_INTREQ_RST   8'h00
`define CSIOR_RDATA_RST    8'h00

// Divider codes as log2 of the division ratio
`define CSIOR_DIV1         3'h0
`define CSIOR_DIV2         3'h1
`define CSIOR_DIV4         3'h2
`define CSIOR_DIV8         3'h3
`define CSIOR_DIV16        3'h4
`define CSIOR_DIV32        3'h5
`define CSIOR_DIV64        3'h6

`endif

// ===== common/csior_pkg.sv
// Types shared by the core system IO register group.
// Assumes the constants header is on the include path.
`include "csior_cfg.svh"

package csior_pkg;

    // System clock source
    typedef enum logic [1:0]
    {
        CSIOR_SRC_HRC  = 2'b00,
        CSIOR_SRC_LRC  = 2'b01,
        CSIOR_SRC_EXT  = 2'b10,
        CSIOR_SRC_NONE = 2'b11
    } csior_src_e;

    // Decoded system clock choice
    typedef struct packed
    {
        logic       valid;
        csior_src_e src;
        logic [2:0] div_log2;
    } csior_clk_s;

    // IO access from the processor core
    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } csior_io_s;

    // Flag results from the arithmetic unit
    typedef struct packed
    {
        logic upd_ov;
        logic upd_hc;
        logic upd_c;
        logic upd_z;
        logic ov;
        logic hc;
        logic c;
        logic z;
    } csior_flag_upd_s;

    // Stack pointer change by call, return or push
    typedef struct packed
    {
        logic       valid;
        logic [7:0] value;
    } csior_sp_upd_s;

endpackage

// ===== verilog/csior_clk_decode.sv
// System clock selection decoder with registered result.
// Assumes the clock mode register value comes from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
`include "csior_cfg.svh"

module csior_clk_decode
(
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              arst_n_i,
    // Clock mode register
    input  wire logic [7:0]        mode_i,
    // Decoded choice
    output var  csior_pkg::csior_clk_s clk_sel_o
);
    import csior_pkg::*;

    csior_clk_s next_sel;
    logic [2:0] sel;

    assign sel = mode_i[`CSIOR_CM_SEL_HI:`CSIOR_CM_SEL_LO];

    // Two code tables; the type bit picks one
    always_comb
    begin
        next_sel = '{1'b1, CSIOR_SRC_NONE, `CSIOR_DIV1};
        if (!mode_i[`CSIOR_CM_TYPE])
        begin
            unique case (sel)
                3'h0: next_sel = '{1'b1, CSIOR_SRC_HRC, `CSIOR_DIV4};
                3'h1: next_sel = '{1'b1, CSIOR_SRC_HRC, `CSIOR_DIV2};
                3'h2: next_sel = '{1'b0, CSIOR_SRC_NONE, `CSIOR_DIV1};
                3'h3: next_sel = '{1'b1, CSIOR_SRC_EXT, `CSIOR_DIV4};
                3'h4: next_sel = '{1'b1, CSIOR_SRC_EXT, `CSIOR_DIV2};
                3'h5: next_sel = '{1'b1, CSIOR_SRC_EXT, `CSIOR_DIV1};
                3'h6: next_sel = '{1'b1, CSIOR_SRC_LRC, `CSIOR_DIV4};
                3'h7: next_sel = '{1'b1, CSIOR_SRC_LRC, `CSIOR_DIV1};
            endcase
        end
        else
        begin
            unique case (sel)
                3'h0: next_sel = '{1'b1, CSIOR_SRC_HRC, `CSIOR_DIV16};
                3'h1: next_sel = '{1'b1, CSIOR_SRC_HRC, `CSIOR_DIV8};
                3'h2: next_sel = '{1'b1, CSIOR_SRC_LRC, `CSIOR_DIV16};
                3'h3: next_sel = '{1'b1, CSIOR_SRC_HRC, `CSIOR_DIV32};
                3'h4: next_sel = '{1'b1, CSIOR_SRC_HRC, `CSIOR_DIV64};
                3'h5: next_sel = '{1'b1, CSIOR_SRC_EXT, `CSIOR_DIV8};
                3'h6: next_sel = '{1'b0, CSIOR_SRC_NONE, `CSIOR_DIV1};
                3'h7: next_sel = '{1'b0, CSIOR_SRC_NONE, `CSIOR_DIV1};
            endcase
        end
    end

    // Reset value matches low RC undivided, the reset mode code
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            clk_sel_o <= '{1'b1, CSIOR_SRC_LRC, `CSIOR_DIV1};
        else
            clk_sel_o <= next_sel;
    end

endmodule

`default_nettype wire

// ===== verilog/csior_irq_req.sv
// Sticky interrupt request bits and the pending line.
// Assumes source events are one-cycle pulses on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "csior_cfg.svh"

module csior_irq_req
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       arst_n_i,
    // Events and software access
    input  wire logic [7:0] event_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] enable_i,
    // State
    output logic      [7:0] req_o,
    output logic            pending_o
);
    import csior_pkg::*;

    logic [7:0] next_req;

    // A set arriving with the clear still lands
    assign next_req = ((wr_i ? wdata_i : req_o) | event_i) & `CSIOR_IRQ_MASK;

    // Request register
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            req_o <= `CSIOR_INTREQ_RST;
        else
            req_o <= next_req;
    end

    // Pending follows the new request value to save a cycle
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pending_o <= 1'b0;
        else
            pending_o <= |(next_req & enable_i);
    end

endmodule

`default_nettype wire

// ===== verilog/csior_regs.sv
// Core system IO register group: status flags, stack pointer, clock
// mode, interrupt enable and interrupt request.
// Assumes the processor core and all event sources share sys_clk_i.
//
// Function
// - Overflow flag bit 3 set on signed arithmetic overflow.
// - Half-carry bit 2 on low nibble carry or borrow into it.
// - Carry bit 1 on add carry, subtract borrow, or carry shift.
// - Zero bit 0 follows whether a result was zero.
// - Four flags reset to 0, readable, writable; bits 7..4 unused.
// - Stack pointer reads current value; a write replaces it.
// - Type 0 clock select codes; field resets to 111.
// - Type 1 clock select codes; 11x reserved.
// - Mode bit 3 picks the type table; resets to 0.
// - Mode bit 4 enables the high RC oscillator; resets to 1.
// - Mode bit 2 enables low RC; clearing it also stops the watchdog.
// - Mode bit 1 enables the watchdog; resets to 1.
// - Mode bit 0 picks port pin or external reset pin; resets to 0.
// - One enable per source, bit 5 reserved, all reset to 0.
// - Request bits set by hardware events, cleared by software.
`timescale 1ns/1ns
`default_nettype none
`include "csior_cfg.svh"

module csior_regs
(
    // Clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       arst_n_i,
    // IO access from the core
    input  wire csior_pkg::csior_io_s       io_req_i,
    output logic [7:0]                      io_rdata_o,
    // Arithmetic flag results
    input  wire csior_pkg::csior_flag_upd_s alu_upd_i,
    // Stack pointer change by the core
    input  wire csior_pkg::csior_sp_upd_s   sp_upd_i,
    // Interrupt source events
    input  wire logic [7:0]                 irq_event_i,
    // Flags and stack pointer
    output logic [3:0]                      flags_o,
    output logic [7:0]                      sp_o,
    // Clock control
    output csior_pkg::csior_clk_s           clk_sel_o,
    output logic                            high_rc_en_o,
    output logic                            low_rc_en_o,
    output logic                            wdt_en_o,
    output logic                            reset_pin_en_o,
    // Interrupt state
    output logic [7:0]                      irq_enable_o,
    output logic [7:0]                      irq_request_o,
    output logic                            irq_pending_o
);
    import csior_pkg::*;

    //--------------------------------------------------------------
    // Address decode
    //--------------------------------------------------------------

    // Shared by read and write paths
    function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
        hit = (a == r);
    endfunction

    logic       wr_flags;
    logic       wr_stack;
    logic       wr_mode;
    logic       wr_inten;
    logic       wr_intreq;
    logic [7:0] clk_mode;
    logic [7:0] next_rdata;
    logic [7:0] irq_req;
    logic [3:0] next_flags;

    assign wr_flags  = io_req_i.wr && hit(io_req_i.addr, `CSIOR_ADDR_FLAGS);
    assign wr_stack  = io_req_i.wr && hit(io_req_i.addr, `CSIOR_ADDR_STACK);
    assign wr_mode   = io_req_i.wr && hit(io_req_i.addr, `CSIOR_ADDR_CLKMODE);
    assign wr_inten  = io_req_i.wr && hit(io_req_i.addr, `CSIOR_ADDR_INTEN);
    assign wr_intreq = io_req_i.wr && hit(io_req_i.addr, `CSIOR_ADDR_INTREQ);

    //--------------------------------------------------------------
    // Status flags
    //--------------------------------------------------------------

    // The arithmetic result of the same cycle wins over a software write,
    // so an instruction that writes the register and sets flags is exact
    always_comb
    begin
        next_flags = wr_flags ? io_req_i.wdata[3:0] : flags_o;
        if (alu_upd_i.upd_ov)
            next_flags[`CSIOR_FLAG_OV] = alu_upd_i.ov;
        if (alu_upd_i.upd_hc)
            next_flags[`CSIOR_FLAG_HC] = alu_upd_i.hc;
        if (alu_upd_i.upd_c)
            next_flags[`CSIOR_FLAG_C] = alu_upd_i.c;
        if (alu_upd_i.upd_z)
            next_flags[`CSIOR_FLAG_Z] = alu_upd_i.z;
    end

    // Flag register
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            flags_o <= `CSIOR_FLAGS_RST;
        else
            flags_o <= next_flags;
    end

    //--------------------------------------------------------------
    // Stack pointer
    //--------------------------------------------------------------

    // A call or return in the same cycle overrides the software write
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            sp_o <= `CSIOR_STACK_RST;
        else if (sp_upd_i.valid)
            sp_o <= sp_upd_i.value;
        else if (wr_stack)
            sp_o <= io_req_i.wdata;
    end

    //--------------------------------------------------------------
    // Clock mode
    //--------------------------------------------------------------

    // All eight bits are implemented; reserved select codes are stored
    // but flagged as invalid by the decoder
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            clk_mode <= `CSIOR_CLKMODE_RST;
        else if (wr_mode)
            clk_mode <= io_req_i.wdata;
    end

    // Oscillator and pin controls follow the mode register one cycle on,
    // which keeps every output on its own flop
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            high_rc_en_o   <= 1'b1;
            low_rc_en_o    <= 1'b1;
            wdt_en_o       <= 1'b1;
            reset_pin_en_o <= 1'b0;
        end
        else
        begin
            high_rc_en_o   <= clk_mode[`CSIOR_CM_HRC_EN];
            low_rc_en_o    <= clk_mode[`CSIOR_CM_LRC_EN];
            wdt_en_o       <= clk_mode[`CSIOR_CM_WDT_EN]
                              && clk_mode[`CSIOR_CM_LRC_EN];
            reset_pin_en_o <= clk_mode[`CSIOR_CM_RST_PIN];
        end
    end

    // Source and divider decode
    csior_clk_decode u_clk_decode
    (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .mode_i    (clk_mode),
        .clk_sel_o (clk_sel_o)
    );

    //--------------------------------------------------------------
    // Interrupts
    //--------------------------------------------------------------

    // Enable register; reserved bit never stores
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_enable_o <= `CSIOR_INTEN_RST;
        else if (wr_inten)
            irq_enable_o <= io_req_i.wdata & `CSIOR_IRQ_MASK;
    end

    // Sticky request bits and pending line
    csior_irq_req u_irq_req
    (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .event_i   (irq_event_i),
        .wr_i      (wr_intreq),
        .wdata_i   (io_req_i.wdata),
        .enable_i  (irq_enable_o),
        .req_o     (irq_req),
        .pending_o (irq_pending_o)
    );

    // Request copy for the core's interrupt logic
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            irq_request_o <= `CSIOR_INTREQ_RST;
        else
            irq_request_o <= irq_req;
    end

    //--------------------------------------------------------------
    // Read path
    //--------------------------------------------------------------

    // Unmapped addresses read as zero; reserved bits come back zero
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (1'b1)
            hit(io_req_i.addr, `CSIOR_ADDR_FLAGS):
                next_rdata = {4'h0, flags_o};
            hit(io_req_i.addr, `CSIOR_ADDR_STACK):
                next_rdata = sp_o;
            hit(io_req_i.addr, `CSIOR_ADDR_CLKMODE):
                next_rdata = clk_mode;
            hit(io_req_i.addr, `CSIOR_ADDR_INTEN):
                next_rdata = irq_enable_o;
            hit(io_req_i.addr, `CSIOR_ADDR_INTREQ):
                next_rdata = irq_req;
            default:
                next_rdata = 8'h00;
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            io_rdata_o <= `CSIOR_RDATA_RST;
        else if (io_req_i.rd)
            io_rdata_o <= next_rdata;
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_ov_flag_set: assert property (
        alu_upd_i.upd_ov |=> flags_o[`CSIOR_FLAG_OV] == $past(alu_upd_i.ov))
        else $error("overflow flag did not follow the result");

    a_carry_flags: assert property (
        (alu_upd_i.upd_hc && !wr_flags) |=> flags_o[`CSIOR_FLAG_HC] == $past(alu_upd_i.hc))
        else $error("half carry flag did not follow the result");

    a_carry_hold: assert property (
        (!alu_upd_i.upd_c && !wr_flags) |=> $stable(flags_o[`CSIOR_FLAG_C]))
        else $error("carry flag changed without a cause");

    a_zero_flag: assert property (
        alu_upd_i.upd_z ##1 (!alu_upd_i.upd_z && !wr_flags)
        ##1 (io_req_i.rd && hit(io_req_i.addr, `CSIOR_ADDR_FLAGS))
        |=> io_rdata_o[`CSIOR_FLAG_Z] == $past(alu_upd_i.z, 3))
        else $error("zero flag read back wrong");

    a_flags_upper: assert property (
        (io_req_i.rd && hit(io_req_i.addr, `CSIOR_ADDR_FLAGS)) |=> io_rdata_o[7:4] == 4'h0)
        else $error("reserved flag bits read nonzero");

    a_sp_write: assert property (
        (wr_stack && !sp_upd_i.valid) ##1 (!wr_stack && !sp_upd_i.valid)
        ##1 (io_req_i.rd && hit(io_req_i.addr, `CSIOR_ADDR_STACK))
        |=> io_rdata_o == $past(io_req_i.wdata, 3))
        else $error("stack pointer read does not return the write");

    a_wdt_off_lrc: assert property (
        !clk_mode[`CSIOR_CM_LRC_EN] [*2] |-> !wdt_en_o)
        else $error("watchdog runs with low RC off");

    a_hrc_follows: assert property (
        wr_mode ##1 1'b1 |=> high_rc_en_o == $past(io_req_i.wdata[`CSIOR_CM_HRC_EN], 2))
        else $error("high RC enable did not follow the mode write");

    a_type1_resv: assert property (
        (clk_mode[`CSIOR_CM_TYPE] && clk_mode[`CSIOR_CM_SEL_HI:`CSIOR_CM_SEL_HI - 1] == 2'b11)
        |=> !clk_sel_o.valid)
        else $error("reserved type 1 code reported valid");

    a_type0_low_rc_oscillator: assert property (
        (clk_mode[`CSIOR_CM_SEL_HI:`CSIOR_CM_SEL_LO] == 3'b111 && !clk_mode[`CSIOR_CM_TYPE])
        |=> clk_sel_o.src == CSIOR_SRC_LRC
                                        && clk_sel_o.div_log2 == `CSIOR_DIV1)
        else $error("type 0 code 111 did not choose low RC undivided");

    a_pin_select: assert property (
        $rose(clk_mode[`CSIOR_CM_RST_PIN]) |=> reset_pin_en_o)
        else $error("reset pin function not selected");

    a_enable_resv: assert property (
        !irq_enable_o[5])
        else $error("reserved enable bit set");

    a_req_set_wins: assert property (
        (irq_event_i[0] && wr_intreq && !io_req_i.wdata[0]) |=> irq_req[0])
        else $error("event lost against a software clear");

    a_req_sticky: assert property (
        (irq_req[1] && !wr_intreq) |=> irq_req[1])
        else $error("request bit dropped without a clear");

    a_pending_gate: assert property (
        ((irq_req & irq_enable_o) != 8'h00 && !wr_intreq && !wr_inten)
        |=> irq_pending_o [*1])
        else $error("pending not raised for an enabled request");

    a_req_resv: assert property (
        $past(wr_intreq) |-> !irq_req[5])
        else $error("reserved request bit stored a write");

    a_sp_core_wins: assert property (
        sp_upd_i.valid |=> sp_o == $past(sp_upd_i.value))
        else $error("stack pointer missed a core update");

    a_lrc_follows: assert property (
        1'b1 |=> low_rc_en_o == $past(clk_mode[`CSIOR_CM_LRC_EN]))
        else $error("low RC enable did not follow the mode bit");

    a_wdt_enable: assert property (
        (clk_mode[`CSIOR_CM_WDT_EN] && clk_mode[`CSIOR_CM_LRC_EN]) |=> wdt_en_o)
        else $error("watchdog not enabled by the mode bits");

    a_pin_clear: assert property (
        $fell(clk_mode[`CSIOR_CM_RST_PIN]) |=> !reset_pin_en_o)
        else $error("port pin function not restored");

    a_enable_write: assert property (
        wr_inten |=> irq_enable_o == ($past(io_req_i.wdata) & `CSIOR_IRQ_MASK))
        else $error("enable register did not take the write");

    a_req_event: assert property (
        irq_event_i[7] |=> irq_req[7])
        else $error("request bit not set by its event");

    a_req_copy: assert property (
        1'b1 |=> irq_request_o == $past(irq_req))
        else $error("request copy lags by more than a cycle");

endmodule

`default_nettype wire

// ===== test/csior_core_model.sv
// Model of the processor core issuing IO reads and writes.
// Assumes the register group samples requests on sys_clk_i rising edges.
`timescale 1ns/1ns
`default_nettype none

module csior_core_model
(
    // Clock
    input  wire logic                 sys_clk_i,
    // IO bus toward the register group
    output var  csior_pkg::csior_io_s io_req_o,
    input  wire logic [7:0]           io_rdata_i
);
    import csior_pkg::*;

    // Idle bus at time zero
    initial io_req_o = '0;

    // One-cycle write; idle lines invert so stale values never look valid
    task automatic io_write(input logic [5:0] addr, input logic [7:0] data);
        @(posedge sys_clk_i);
        io_req_o <= '{1'b1, 1'b0, addr, data};
        @(posedge sys_clk_i);
        io_req_o <= '{1'b0, 1'b0, ~addr, ~data};
    endtask

    // One-cycle read; data is taken once the accepting edge has landed
    task automatic io_read(input logic [5:0] addr, output logic [7:0] data);
        @(posedge sys_clk_i);
        io_req_o <= '{1'b0, 1'b1, addr, ~io_req_o.wdata};
        @(posedge sys_clk_i);
        io_req_o <= '{1'b0, 1'b0, ~addr, io_req_o.wdata};
        #1;
        data = io_rdata_i;
    endtask
endmodule
`default_nettype wire

// ===== test/core_system_io_registers_test.sv
// Self-checking bench for the core system IO register group.
// Assumes the core model owns the IO bus; the bench drives all else.
`timescale 1ns/1ns
`default_nettype none
`include "csior_cfg.svh"

module core_system_io_registers_test;
    import csior_pkg::*;

    // Register access row: address, data written, data read back
    typedef struct packed
    {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp_rd;
    } csior_row_s;

    localparam csior_row_s ROWS [7] = '{
        '{`CSIOR_ADDR_FLAGS, 8'hFF, 8'h0F}, '{`CSIOR_ADDR_STACK, 8'hA5, 8'hA5},
        '{`CSIOR_ADDR_STACK, 8'h5A, 8'h5A}, '{`CSIOR_ADDR_INTEN, 8'hFF, 8'hDF},
        '{6'h01, 8'hAA, 8'h00}, '{6'h3F, 8'h55, 8'h00},
        '{`CSIOR_ADDR_FLAGS, 8'h00, 8'h00}};
    // Decoded clock {valid, src, div_log2} indexed by {type, select}
    localparam logic [5:0] CLK_TAB [16] = '{6'h22, 6'h21, 6'h18, 6'h32, 6'h31,
        6'h30, 6'h2A, 6'h28, 6'h24, 6'h23, 6'h2C, 6'h25, 6'h26, 6'h33, 6'h18, 6'h18};

    logic            sys_clk_i;
    logic            arst_n;
    csior_io_s       io_req;
    logic [7:0]      io_rdata;
    csior_flag_upd_s alu_upd;
    csior_sp_upd_s   sp_upd;
    logic [7:0]      irq_event;
    logic [3:0]      flags;
    logic [7:0]      sp;
    csior_clk_s      clk_sel;
    logic            high_rc_en;
    logic            low_rc_en;
    logic            wdt_en;
    logic            reset_pin_en;
    logic [7:0]      irq_enable;
    logic [7:0]      irq_request;
    logic            irq_pending;
    int              n_mismatch;
    int              tests_run;
    logic [7:0]      mode;
    logic [7:0]      seen;
    logic [5:0]      exp_sel;

    csior_regs dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n), .io_req_i(io_req),
        .io_rdata_o(io_rdata), .alu_upd_i(alu_upd), .sp_upd_i(sp_upd),
        .irq_event_i(irq_event), .flags_o(flags), .sp_o(sp), .clk_sel_o(clk_sel),
        .high_rc_en_o(high_rc_en), .low_rc_en_o(low_rc_en), .wdt_en_o(wdt_en),
        .reset_pin_en_o(reset_pin_en), .irq_enable_o(irq_enable),
        .irq_request_o(irq_request), .irq_pending_o(irq_pending));

    csior_core_model core_model (.sys_clk_i(sys_clk_i), .io_req_o(io_req),
        .io_rdata_i(io_rdata));

    // 10 MHz clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic rd_chk(input string name, input logic [5:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        core_model.io_read(addr, data);
        check(name, exp, data);
    endtask

    // Pulses land one edge, clear the next; results are looked at after it
    task automatic pulse_alu(input logic [7:0] v);
        @(posedge sys_clk_i);
        alu_upd <= csior_flag_upd_s'(v);
        @(posedge sys_clk_i);
        alu_upd <= '0;
        #1;
    endtask

    task automatic pulse_evt(input logic [7:0] v);
        @(posedge sys_clk_i);
        irq_event <= v;
        @(posedge sys_clk_i);
        irq_event <= '0;
        #1;
    endtask

    task automatic tally_and_finish();
        $display("Checks run %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Guard against a hang anywhere in the sequence
    initial
    begin
        #10000000;
        n_mismatch++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        n_mismatch = 0;
        tests_run = 0;
        arst_n = 1'b0;
        alu_upd = '0;
        sp_upd = '0;
        irq_event = '0;
        repeat (2) @(posedge sys_clk_i);
        arst_n <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        check("flags_rst", 8'h00, {4'h0, flags});
        check("clk_sel_rst", 8'h28, {2'b00, clk_sel});
        check("osc_rst", 8'h0E, {4'h0, high_rc_en, low_rc_en, wdt_en, reset_pin_en});
        check("irq_rst", 8'h00, irq_enable | irq_request | {7'h0, irq_pending});
        rd_chk("mode_rst", `CSIOR_ADDR_CLKMODE, `CSIOR_CLKMODE_RST);
        for (int i = 0; i < 7; i++)
        begin
            core_model.io_write(ROWS[i].addr, ROWS[i].wdata);
            rd_chk("row_read", ROWS[i].addr, ROWS[i].exp_rd);
        end
        // Every select code under both types, oscillator bits varied alongside
        for (int i = 0; i < 16; i++)
        begin
            mode = {i[2:0], i[0], i[3], i[1], ~i[2], i[3] ^ i[1]};
            core_model.io_write(`CSIOR_ADDR_CLKMODE, mode);
            @(posedge sys_clk_i);
            #1;
            exp_sel = CLK_TAB[i];
            seen = {2'b00, clk_sel};
            if (!exp_sel[5])
                seen[2:0] = 3'b000;
            check("clk_sel", {2'b00, exp_sel}, seen);
            check("osc", {4'h0, mode[4], mode[2], mode[1] & mode[2], mode[0]},
                {4'h0, high_rc_en, low_rc_en, wdt_en, reset_pin_en});
        end
        // Each flag set then cleared on its own strobe, others untouched
        for (int b = 0; b < 4; b++)
        begin
            pulse_alu(8'h11 << b);
            check("flag_set", (8'h02 << b) - 8'h01, {4'h0, flags});
        end
        for (int b = 0; b < 4; b++)
        begin
            pulse_alu(8'h10 << b);
            check("flag_clr", 8'h0F & ~((8'h02 << b) - 8'h01), {4'h0, flags});
        end
        // Core-side updates beat a software write in the same cycle
        fork
            core_model.io_write(`CSIOR_ADDR_FLAGS, 8'h0F);
            pulse_alu(8'hF5);
        join
        check("flag_race", 8'h05, {4'h0, flags});
        rd_chk("flag_rd", `CSIOR_ADDR_FLAGS, 8'h05);
        fork
            core_model.io_write(`CSIOR_ADDR_STACK, 8'h11);
            begin
                @(posedge sys_clk_i);
                sp_upd <= '{1'b1, 8'h77};
                @(posedge sys_clk_i);
                sp_upd <= '0;
            end
        join
        rd_chk("sp_race", `CSIOR_ADDR_STACK, 8'h77);
        check("sp_out", 8'h77, sp);
        // Requests latch with enables off, then pending follows the enable
        core_model.io_write(`CSIOR_ADDR_INTEN, 8'h00);
        pulse_evt(8'hFF);
        check("pend_off", 8'h00, {7'h0, irq_pending});
        rd_chk("req_all", `CSIOR_ADDR_INTREQ, 8'hDF);
        check("req_copy", 8'hDF, irq_request);
        core_model.io_write(`CSIOR_ADDR_INTEN, 8'h40);
        @(posedge sys_clk_i);
        #1;
        check("pend_on", 8'h01, {7'h0, irq_pending});
        check("en_out", 8'h40, irq_enable);
        core_model.io_write(`CSIOR_ADDR_INTREQ, 8'h00);
        #1;
        check("pend_clr", 8'h00, {7'h0, irq_pending});
        rd_chk("req_clr", `CSIOR_ADDR_INTREQ, 8'h00);
        // An event in the clearing cycle must not be lost
        fork
            core_model.io_write(`CSIOR_ADDR_INTREQ, 8'h00);
            pulse_evt(8'h41);
        join
        check("pend_race", 8'h01, {7'h0, irq_pending});
        rd_chk("req_race", `CSIOR_ADDR_INTREQ, 8'h41);
        tally_and_finish();
    end
endmodule
`default_nettype wire
